// File: timer_unit_defs.vh
// Register map, field layout, reset values and prescaler taps of the twelve-channel timer unit.
`ifndef TIMER_UNIT_DEFS_VH
`define TIMER_UNIT_DEFS_VH

// Channel count and widths.
`define TU_CHANNELS 12
`define TU_CAP_CHANNEL 2
`define TU_EXT_CHANNELS 3
`define TU_IDX_W 7
`define TU_CTRL_W 10

// Word indexes on the bus; the byte address is four times the index.
`define TU_IDX_RUN0 7'h00
`define TU_IDX_CH_BASE 7'h04
`define TU_IDX_CH_STRIDE 7'h04
`define TU_OFS_RELOAD 7'h00
`define TU_OFS_COUNT 7'h01
`define TU_OFS_CTRL 7'h02
`define TU_IDX_CAPTURE 7'h40
`define TU_RUN_REGS 4
`define TU_RUN_BITS 3

// Control register field positions.
`define TU_F_PSEL 2:0
`define TU_F_EDGE 4:3
`define TU_F_EDGE_BOTH 4
`define TU_F_EDGE_FALL 3
`define TU_F_UIE 5
`define TU_F_CAPM 7:6
`define TU_F_CAPM_ON 7
`define TU_F_UNF 8
`define TU_F_CAPF 9
`define TU_CTRL_RW_MASK 10'h03F
`define TU_CTRL_CAPM_MASK 10'h0C0

// Prescale codes and capture mode codes.
`define TU_PS_DIV4 3'h0
`define TU_PS_DIV16 3'h1
`define TU_PS_DIV64 3'h2
`define TU_PS_DIV256 3'h3
`define TU_PS_DIV1024 3'h4
`define TU_PS_EXT 3'h7
`define TU_CAPM_IRQ 2'h3

// Prescaler counter width and the low-bit taps of each divider.
`define TU_PRE_W 10
`define TU_TAP4 1:0
`define TU_TAP16 3:0
`define TU_TAP64 5:0
`define TU_TAP256 7:0
`define TU_TAP1024 9:0

// Reset values.
`define TU_RST_COUNT 32'hFFFFFFFF
`define TU_RST_RELOAD 32'hFFFFFFFF
`define TU_RST_CTRL 10'h000
`define TU_RST_CAPTURE 32'h00000000
`define TU_ZERO32 32'h00000000

`endif

// File: timer_unit.v
// Twelve-channel reload down-counting timer with channel-2 input capture behind an Avalon-MM slave.
//
// Summary of operation
// - Each channel: 32-bit counter plus reload constant.
// - Run bit set counts; cleared holds value.
// - Underflow sets flag, reloads, keeps counting.
// - Underflow interrupt when flag and enable set.
// - Prescale code picks divider, or external edges on channels 0-2.
// - Edge field picks rising, falling or both.
// - Capture mode: off, reserved, on, on with interrupt.
// - Capture copies counter only while flag clear.
// - Capture value register is read-only, capture-written.
// - Capture interrupt when flag set, mode 11.
// - Twelve underflow interrupts, one capture interrupt.
// - Capture bits reserved, read zero elsewhere.
// - Writing one keeps flag; zero clears it.
// - Counter read returns value before coincident decrement.
// - Standby freezes counting and the bus handshake alike.
// - Capture event sets capture flag; zero-write clears.
// - Underflow sets underflow flag; zero-write clears.
`timescale 1ns/1ps
`default_nettype none
`include "timer_unit_defs.vh"

module timer_unit (
	input wire clock,
	input wire rst_n,
	input wire clockEnable,
	input wire [8:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire extCountPin,
	output reg [11:0] underflowIrq,
	output reg captureIrq
);

	// Merges write data into an old word under the byte enables.
	// Lanes left out keep their old bytes, so software may update one byte of a
	// counter or reload constant without a read-modify-write on the bus.
	function [31:0] mergeBytes;
		input [31:0] oldWord;
		input [31:0] newWord;
		input [3:0] be;
		integer b;
		begin
			mergeBytes = oldWord;
			for (b = 0; b < 4; b = b + 1) begin
				if (be[b]) begin
					mergeBytes[b*8 +: 8] = newWord[b*8 +: 8];
				end
			end
		end
	endfunction

	// Picks the selected edge of the synchronised pin.
	// The same decode serves counting and capture, which is why it is a function.
	// With the high bit set the low bit is ignored and both edges count.
	function edgeHit;
		input [1:0] edgeSel;
		input rise;
		input fall;
		begin
			if (edgeSel[1]) begin
				edgeHit = rise | fall;
			end else if (edgeSel[0]) begin
				edgeHit = fall;
			end else begin
				edgeHit = rise;
			end
		end
	endfunction

	// Channel register state, all in flip-flops indexed by channel.
	// Flip-flops rather than a RAM, because every counter must be able to change
	// in the same clock as every other one and as a bus access.
	reg [31:0] count_q [0:`TU_CHANNELS-1]; // Down-counters.
	reg [31:0] reload_q [0:`TU_CHANNELS-1]; // Reload constants.
	reg [`TU_CTRL_W-1:0] ctrl_q [0:`TU_CHANNELS-1]; // Control fields and flags.
	reg [`TU_CHANNELS-1:0] runBits_q; // One run bit per channel.
	reg [31:0] captureValue_q; // Captured channel-2 count.
	reg [`TU_PRE_W-1:0] prescale_q; // Free-running prescaler.
	reg pinSync1_q; // First synchroniser stage, read only by the second.
	reg pinSync2_q; // Second synchroniser stage.
	reg pinPrev_q; // Delayed copy for edge detection.

	// Bus handshake terms: a read is sampled while waitrequest is high, a write lands when it is low.
	// Sampling the read one edge early lets the read data come from a flip-flop
	// and still stand at the edge where the master sees waitrequest low.
	wire [`TU_IDX_W-1:0] wordIdx = avs_address[8:2];
	wire writeGo = avs_write & ~avs_waitrequest;
	wire readGo = avs_read & avs_waitrequest;

	// Edge pulses come from the second and third stage only, never the first.
	// An edge is seen three clocks after the pin moves; a pin that toggles faster
	// than half the clock may lose edges in this detector.
	wire pinRise = pinSync2_q & ~pinPrev_q;
	wire pinFall = ~pinSync2_q & pinPrev_q;

	// Internal divider strobes, each high one clock in its period.
	// All channels share one prescaler, so two channels on the same divider
	// always count on the same edge.
	wire tap4 = &prescale_q[`TU_TAP4];
	wire tap16 = &prescale_q[`TU_TAP16];
	wire tap64 = &prescale_q[`TU_TAP64];
	wire tap256 = &prescale_q[`TU_TAP256];
	wire tap1024 = &prescale_q[`TU_TAP1024];

	// Per-channel combinational decode.
	wire [`TU_CHANNELS-1:0] tick; // Count clock event.
	wire [`TU_CHANNELS-1:0] underflow; // Counter at zero on a counting event.
	wire [`TU_CHANNELS-1:0] selReload; // Write strobe to the reload constant.
	wire [`TU_CHANNELS-1:0] selCount; // Write strobe to the counter.
	wire [`TU_CHANNELS-1:0] selCtrl; // Write strobe to the control register.
	wire [`TU_CHANNELS-1:0] clrUnf; // Zero written into the underflow flag.

	genvar g;
	generate
		for (g = 0; g < `TU_CHANNELS; g = g + 1) begin : gChan
			// The channel's first word index; the integer sum is cut to the index width on purpose.
			// The last channel's base still fits the index, so nothing is lost by the cut.
			localparam integer BASE_I = `TU_IDX_CH_BASE + g * `TU_IDX_CH_STRIDE;
			localparam [`TU_IDX_W-1:0] BASE = BASE_I[`TU_IDX_W-1:0];
			wire [2:0] psel = ctrl_q[g][`TU_F_PSEL];
			wire extOk = (g < `TU_EXT_CHANNELS);
			reg tickSel;
			// Count-clock selection; prohibited codes and external on channels three up never count.
			always @* begin
				case (psel)
					`TU_PS_DIV4: tickSel = tap4;
					`TU_PS_DIV16: tickSel = tap16;
					`TU_PS_DIV64: tickSel = tap64;
					`TU_PS_DIV256: tickSel = tap256;
					`TU_PS_DIV1024: tickSel = tap1024;
					`TU_PS_EXT: tickSel = extOk & edgeHit(ctrl_q[g][`TU_F_EDGE], pinRise, pinFall);
					default: tickSel = 1'b0;
				endcase
			end
			assign tick[g] = tickSel & runBits_q[g];
			assign underflow[g] = tick[g] & (count_q[g] == `TU_ZERO32);
			assign selReload[g] = writeGo & (wordIdx == BASE + `TU_OFS_RELOAD);
			assign selCount[g] = writeGo & (wordIdx == BASE + `TU_OFS_COUNT);
			assign selCtrl[g] = writeGo & (wordIdx == BASE + `TU_OFS_CTRL);
			assign clrUnf[g] = selCtrl[g] & avs_byteenable[1] & ~avs_writedata[`TU_F_UNF];
		end
	endgenerate

	// Capture event on channel 2: enabled mode and the chosen pin edge.
	// The reserved mode code behaves as off, since only the high mode bit enables capture.
	// Capture does not need the channel to run; it copies whatever the counter holds.
	wire [`TU_CTRL_W-1:0] ctrlCap = ctrl_q[`TU_CAP_CHANNEL];
	wire captureEvent = ctrlCap[`TU_F_CAPM_ON] & edgeHit(ctrlCap[`TU_F_EDGE], pinRise, pinFall);
	wire clrCapf = selCtrl[`TU_CAP_CHANNEL] & avs_byteenable[1] & ~avs_writedata[`TU_F_CAPF];

	// Read multiplexer; unmapped words and reserved bits read as zero.
	// Reading never has side effects, so a stray read cannot clear a flag.
	// Flags are cleared only by writes.
	reg [31:0] readMux;
	integer r;
	always @* begin
		readMux = `TU_ZERO32;
		for (r = 0; r < `TU_RUN_REGS; r = r + 1) begin
			if (wordIdx == `TU_IDX_RUN0 + r[`TU_IDX_W-1:0]) begin
				readMux[`TU_RUN_BITS-1:0] = runBits_q[r*`TU_RUN_BITS +: `TU_RUN_BITS];
			end
		end
		for (r = 0; r < `TU_CHANNELS; r = r + 1) begin
			if (wordIdx == `TU_IDX_CH_BASE + r[`TU_IDX_W-1:0] * `TU_IDX_CH_STRIDE + `TU_OFS_RELOAD) begin
				readMux = reload_q[r];
			end
			// Sampled before the same edge's decrement lands, so the older value is returned.
			if (wordIdx == `TU_IDX_CH_BASE + r[`TU_IDX_W-1:0] * `TU_IDX_CH_STRIDE + `TU_OFS_COUNT) begin
				readMux = count_q[r];
			end
			if (wordIdx == `TU_IDX_CH_BASE + r[`TU_IDX_W-1:0] * `TU_IDX_CH_STRIDE + `TU_OFS_CTRL) begin
				readMux[`TU_CTRL_W-1:0] = ctrl_q[r];
			end
		end
		if (wordIdx == `TU_IDX_CAPTURE) begin
			readMux = captureValue_q;
		end
	end

	// Bus slave: one wait cycle on every access, then a single completion cycle.
	// The fixed latency keeps the slave simple; back-to-back accesses each pay the
	// wait cycle again, which costs little on a timer.
	// Low clockEnable freezes the handshake as well, which models module standby.
	always @(posedge clock) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= `TU_ZERO32;
		end else if (clockEnable) begin
			if ((avs_read | avs_write) & avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
			end else begin
				avs_waitrequest <= 1'b1;
			end
			if (readGo) begin
				avs_readdata <= readMux;
			end
		end
	end

	// Pin synchroniser and prescaler; both freeze with the clock enable.
	// The prescaler is never cleared by software, so the first tick after a start
	// may come anywhere within one divider period.
	always @(posedge clock) begin
		if (!rst_n) begin
			pinSync1_q <= 1'b0;
			pinSync2_q <= 1'b0;
			pinPrev_q <= 1'b0;
			prescale_q <= {`TU_PRE_W{1'b0}};
		end else if (clockEnable) begin
			pinSync1_q <= extCountPin;
			pinSync2_q <= pinSync1_q;
			pinPrev_q <= pinSync2_q;
			prescale_q <= prescale_q + 1'b1;
		end
	end

	// Channel state: counters, reload constants, control fields, flags, run bits and capture.
	// A bus write to a counter wins over counting; software is expected to stop first anyway.
	// Flags are set by hardware and cleared by software in this one process only.
	integer i;
	always @(posedge clock) begin
		if (!rst_n) begin
			for (i = 0; i < `TU_CHANNELS; i = i + 1) begin
				count_q[i] <= `TU_RST_COUNT;
				reload_q[i] <= `TU_RST_RELOAD;
				ctrl_q[i] <= `TU_RST_CTRL;
			end
			runBits_q <= {`TU_CHANNELS{1'b0}};
			captureValue_q <= `TU_RST_CAPTURE;
		end else if (clockEnable) begin
			for (i = 0; i < `TU_CHANNELS; i = i + 1) begin
				// Counter: write, else reload on underflow, else decrement.
				if (selCount[i]) begin
					count_q[i] <= mergeBytes(count_q[i], avs_writedata, avs_byteenable);
				end else if (underflow[i]) begin
					count_q[i] <= reload_q[i];
				end else if (tick[i]) begin
					count_q[i] <= count_q[i] - 1'b1;
				end
				if (selReload[i]) begin
					reload_q[i] <= mergeBytes(reload_q[i], avs_writedata, avs_byteenable);
				end
				// Writable fields; capture mode lives only on channel 2.
				if (selCtrl[i]) begin
					ctrl_q[i][`TU_F_PSEL] <= avs_byteenable[0] ? avs_writedata[`TU_F_PSEL] : ctrl_q[i][`TU_F_PSEL];
					ctrl_q[i][`TU_F_EDGE] <= avs_byteenable[0] ? avs_writedata[`TU_F_EDGE] : ctrl_q[i][`TU_F_EDGE];
					ctrl_q[i][`TU_F_UIE] <= avs_byteenable[0] ? avs_writedata[`TU_F_UIE] : ctrl_q[i][`TU_F_UIE];
					if (i == `TU_CAP_CHANNEL && avs_byteenable[0]) begin
						ctrl_q[i][`TU_F_CAPM] <= avs_writedata[`TU_F_CAPM];
					end
				end
				// A same-cycle underflow beats a clearing write, so no event is lost.
				if (underflow[i]) begin
					ctrl_q[i][`TU_F_UNF] <= 1'b1;
				end else if (clrUnf[i]) begin
					ctrl_q[i][`TU_F_UNF] <= 1'b0;
				end
			end
			// Capture flag and value; the flag is never set on other channels, which keeps them at zero.
			if (captureEvent) begin
				ctrl_q[`TU_CAP_CHANNEL][`TU_F_CAPF] <= 1'b1;
				if (!ctrlCap[`TU_F_CAPF]) begin
					captureValue_q <= count_q[`TU_CAP_CHANNEL];
				end
			end else if (clrCapf) begin
				ctrl_q[`TU_CAP_CHANNEL][`TU_F_CAPF] <= 1'b0;
			end
			// Run bits, three per run register in the low byte.
			for (i = 0; i < `TU_RUN_REGS; i = i + 1) begin
				if (writeGo && avs_byteenable[0] && wordIdx == `TU_IDX_RUN0 + i[`TU_IDX_W-1:0]) begin
					runBits_q[i*`TU_RUN_BITS +: `TU_RUN_BITS] <= avs_writedata[`TU_RUN_BITS-1:0];
				end
			end
		end
	end

	// Interrupt outputs, registered so they come straight from flip-flops; one clock behind the flags.
	// The lag of one clock is the price of glitch-free interrupt lines.
	// Clearing an enable or a flag drops its line one clock later.
	integer j; // Channel loop index of this process alone.
	always @(posedge clock) begin
		if (!rst_n) begin
			underflowIrq <= {`TU_CHANNELS{1'b0}};
			captureIrq <= 1'b0;
		end else if (clockEnable) begin
			for (j = 0; j < `TU_CHANNELS; j = j + 1) begin
				underflowIrq[j] <= ctrl_q[j][`TU_F_UNF] & ctrl_q[j][`TU_F_UIE];
			end
			captureIrq <= ctrlCap[`TU_F_CAPF] & (ctrlCap[`TU_F_CAPM] == `TU_CAPM_IRQ);
		end
	end

endmodule // timer_unit
`default_nettype wire

// File: timer_unit_monitor.sv
// Concurrent checks on the timer unit ports.
`timescale 1ns/1ps
`default_nettype none
module timer_unit_monitor (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clockEnable,
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic extCountPin,
	input wire logic [11:0] underflowIrq,
	input wire logic captureIrq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Word index, channel and decoded register kinds.
	wire logic [6:0] idx = avs_address[8:2];
	wire logic [6:0] ofs = idx - 7'h04;
	wire logic [3:0] ch = ofs[5:2];
	wire logic ctl = idx >= 7'h04 && idx < 7'h34 && ofs[1:0] == 2'h2;
	wire logic hole = idx > 7'h40 || (idx >= 7'h34 && idx < 7'h40) || (idx >= 7'h04 && ofs[1:0] == 2'h3);
	// A stalled clock enable freezes the handshake, so every request term needs it.
	wire logic rq = avs_read && avs_waitrequest && clockEnable;
	wire logic wd = avs_write && !avs_waitrequest && clockEnable;
	a_wait_one_cycle: assert property ($fell(avs_waitrequest) && clockEnable |=> avs_waitrequest)
		else $error("wait low too long");
	a_request_answered: assert property ((avs_read || avs_write) && avs_waitrequest && clockEnable
		|=> !avs_waitrequest)
		else $error("no answer");
	a_idle_ready: assert property (!avs_read && !avs_write && clockEnable |=> avs_waitrequest)
		else $error("wait low when idle");
	a_hole_reads_zero: assert property (rq && hole |=> avs_readdata == 32'h0)
		else $error("hole not zero");
	a_run_reserved: assert property (rq && idx < 7'h04 |=> avs_readdata[31:3] == 29'h0)
		else $error("run bits high");
	a_ctrl_reserved: assert property (rq && ctl |=> avs_readdata[31:10] == 22'h0 &&
		(ch == 4'h2 || (avs_readdata[9:6] & 4'hB) == 4'h0))
		else $error("ctrl bits high");
	a_uirq_masked: assert property (wd && ctl && avs_byteenable[0] && !avs_writedata[5]
		##1 clockEnable |=> !underflowIrq[$past(ch, 2)])
		else $error("irq not masked");
	a_cirq_mode: assert property (wd && ctl && ch == 4'h2 && avs_byteenable[0] &&
		avs_writedata[7:6] != 2'h3 ##1 clockEnable |=> !captureIrq)
		else $error("capture irq wrong mode");
	c_capture_irq: cover property (captureIrq);
	c_underflow_irq: cover property (|underflowIrq);
	c_ctrl_write: cover property (wd && ctl);
endmodule // timer_unit_monitor
bind timer_unit timer_unit_monitor monitor (.clock, .rst_n, .clockEnable, .avs_address, .avs_read, .avs_write,
	.avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .extCountPin, .underflowIrq, .captureIrq);
`default_nettype wire

// File: test_multi_channel_reload_timer_capture.sv
// Self-checking bench for the reload timer with capture.
`timescale 1ns/1ps
`default_nettype none
module test_multi_channel_reload_timer_capture;
	logic clock, rst_n, clockEnable, avs_read, avs_write, avs_waitrequest, extCountPin, captureIrq;
	logic [8:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd, v;
	logic [11:0] underflowIrq;
	int numErrors, checks, seed, n, ch;
	timer_unit DUT (.clock, .rst_n, .clockEnable, .avs_address, .avs_read, .avs_write, .avs_byteenable,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .extCountPin, .underflowIrq, .captureIrq);
	// The 20 ns clock.
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// A hang counts as a mismatch.
	initial begin
		repeat (30000) @(posedge clock);
		numErrors++;
		summarize();
	end
	task automatic summarize();
		$display("checks=%0d errors=%0d", checks, numErrors);
		if (numErrors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			numErrors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One bus access, held until waitrequest is sampled low.
	// Only the watchdog ends a wait that never gets an answer.
	task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clock);
		avs_address <= {a, 2'h0};
		avs_writedata <= d;
		avs_byteenable <= b;
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge clock);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rc(input logic [6:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		check(rd, e);
	endtask
	// Pin change, then time for the synchroniser and the edge detector.
	task automatic pin(input logic p);
		@(posedge clock);
		extCountPin <= p;
		repeat (6) @(posedge clock);
	endtask
	function automatic logic [6:0] ix(input int c, input int r);
		return 7'(4 + 4 * c + r);
	endfunction
	function automatic logic [31:0] edges(input int e);
		return (e >= 2) ? 32'h4 : 32'h2;
	endfunction
	initial begin
		seed = 13407;
		rst_n = 1'b0;
		clockEnable = 1'b1;
		{avs_read, avs_write, extCountPin} = 3'h0;
		avs_address = 9'h000;
		avs_byteenable = 4'h0;
		avs_writedata = 32'h0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		rc(ix(5, 1), 32'hFFFFFFFF);
		rc(7'h7F, 32'h0);
		// Random reload constants on random channels read back whole.
		repeat (4) begin
			ch = {$random(seed)} % 12;
			v = $random(seed);
			bus(1'b1, ix(ch, 0), v, 4'hF);
			rc(ix(ch, 0), v);
		end
		// Underflow on channel 0 reloads, flags and interrupts; its registers are written while it is stopped.
		bus(1'b1, ix(0, 0), 32'h40, 4'hF);
		bus(1'b1, ix(0, 1), 32'h2, 4'hF);
		bus(1'b1, ix(0, 2), 32'h20, 4'hF);
		bus(1'b1, 7'h00, 32'h1, 4'hF);
		for (n = 0; n < 99 && underflowIrq[0] !== 1'b1; n++)
			@(posedge clock);
		check(underflowIrq, 12'h1);
		bus(1'b1, 7'h00, 32'h0, 4'hF);
		bus(1'b0, ix(0, 1), 32'h0, 4'hF);
		check(rd > 32'h3B && rd <= 32'h40, 32'h1);
		rc(ix(0, 2), 32'h120);
		// Flag writes use lane 1 alone, so every other control bit keeps its value.
		bus(1'b1, ix(0, 2), 32'h100, 4'h2);
		rc(ix(0, 2), 32'h120);
		bus(1'b1, ix(0, 2), 32'h0, 4'h2);
		rc(ix(0, 2), 32'h20);
		check(underflowIrq, 12'h0);
		// Capture on channel 2 with an internal count clock; a set flag protects the value.
		v = $random(seed);
		bus(1'b1, ix(2, 1), v, 4'hF);
		bus(1'b1, ix(2, 2), 32'h80, 4'hF);
		pin(1'b1);
		check(captureIrq, 32'h0);
		rc(7'h40, v);
		rc(ix(2, 2), 32'h280);
		bus(1'b1, ix(2, 2), 32'hC0, 4'h1);
		// The interrupt is registered behind flag and mode, so it shows one edge after the write.
		repeat (2) @(posedge clock);
		check(captureIrq, 32'h1);
		bus(1'b1, ix(2, 1), ~v, 4'hF);
		pin(1'b0);
		pin(1'b1);
		bus(1'b1, 7'h40, ~v, 4'hF);
		rc(7'h40, v);
		bus(1'b1, ix(2, 2), 32'h0, 4'h2);
		rc(ix(2, 2), 32'hC0);
		check(captureIrq, 32'h0);
		pin(1'b0);
		// External edges per edge code, only on channels that may take the pin as source.
		for (int e = 0; e < 4; e++) begin
			ch = (e < 3) ? 1 : 0;
			bus(1'b1, ix(ch, 1), 32'h64, 4'hF);
			bus(1'b1, ix(ch, 2), 32'h7 | (e << 3), 4'hF);
			bus(1'b1, 7'h00, 32'h1 << ch, 4'hF);
			repeat (2) begin
				pin(1'b1);
				pin(1'b0);
			end
			bus(1'b1, 7'h00, 32'h0, 4'hF);
			rc(ix(ch, 1), 32'h64 - edges(e));
		end
		// Each divider over 2048 cycles on channel 7; only the five legal internal codes are used.
		for (int c = 0; c < 5; c++) begin
			bus(1'b1, ix(7, 1), 32'h1000, 4'hF);
			bus(1'b1, ix(7, 2), 32'(c), 4'hF);
			bus(1'b1, 7'h02, 32'h2, 4'hF);
			repeat (2045) @(posedge clock);
			bus(1'b1, 7'h02, 32'h0, 4'hF);
			bus(1'b0, ix(7, 1), 32'h0, 4'hF);
			n = 32'h1000 - rd;
			check(n >= (512 >> 2 * c) - 1 && n <= (512 >> 2 * c) + 1, 32'h1);
		end
		// Standby: a low clock enable freezes counter and prescaler, so four enabled edges give one tick.
		bus(1'b1, ix(7, 1), 32'h1000, 4'hF);
		bus(1'b1, ix(7, 2), 32'h0, 4'hF);
		bus(1'b1, 7'h02, 32'h2, 4'hF);
		@(posedge clock);
		clockEnable <= 1'b0;
		repeat (400) @(posedge clock);
		clockEnable <= 1'b1;
		bus(1'b1, 7'h02, 32'h0, 4'hF);
		rc(ix(7, 1), 32'hFFF);
		summarize();
	end
endmodule // test_multi_channel_reload_timer_capture
`default_nettype wire
